/* File: bench/link_host_model.sv */
// host-side model that drives chopped and full write bursts with crc onto the link pins
`timescale 1ns/10ps
`default_nettype none
module link_host_model (
    // link pins
    output logic link_strobe,
    output logic link_wr_cmd,
    output logic link_a2,
    output logic link_bc4,
    output logic [15:0] link_dq,
    output logic [1:0] link_dm_n
);
    logic tick;
    logic [7:0] calc_lo;
    logic [7:0] calc_hi;

    // own 20 ns time base, offset so its edges never meet the block clock
    initial begin
        tick = 1'b0;
        #3;
        forever #10 tick = ~tick;
    end

    initial begin
        {link_strobe, link_wr_cmd, link_a2, link_bc4} = 4'h0;
        link_dq = 16'h0000;
        link_dm_n = 2'h3;
    end

    // serial tree over 72 inputs, index lane*8+beat, lane 8 is the mask lane, highest index first
    function automatic logic [7:0] tree_crc(input logic [7:0][8:0] d, input logic bc4,
            input logic dm_en);
        logic [7:0] c;
        logic t;
        int lane;
        int beat;
        c = 8'h00;
        for (int i = 71; i >= 0; i--) begin
            lane = i / 8;
            beat = i % 8;
            if (lane == 8 && !dm_en) t = 1'b1;
            else if (!bc4) t = d[beat][lane];
            else t = (beat < 4) ? d[beat][lane] : 1'b1;
            c = {c[6:0], 1'b0} ^ ((c[7] ^ t) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : tree_crc

    // bad flips bit 0 of a byte's crc, the only fault the bench asks for
    task automatic send(input logic a2, input logic bc4, input logic crc_on, input logic dm_en,
            input logic [7:0][15:0] dq_d, input logic [7:0][1:0] dm_d, input logic [1:0] bad);
        crc_chk_pkg::beat_t [9:0] ui;
        logic [7:0][8:0] lo;
        logic [7:0][8:0] hi;
        int n;
        for (int b = 0; b < 8; b++) begin
            lo[b] = {dm_d[b][0], dq_d[b][7:0]};
            hi[b] = {dm_d[b][1], dq_d[b][15:8]};
        end
        calc_lo = tree_crc(lo, bc4, dm_en);
        calc_hi = tree_crc(hi, bc4, dm_en);
        for (int b = 0; b < 10; b++) begin
            ui[b] = '1;
            if (b == 8) begin
                ui[b].lo[7:0] = calc_lo ^ {7'h00, bad[0]};
                ui[b].hi[7:0] = calc_hi ^ {7'h00, bad[1]};
            end else if (b < 8 && !(bc4 && b > 3)) begin
                ui[b].lo = lo[b];
                ui[b].hi = hi[b];
            end
        end
        n = crc_on ? 10 : 8;
        @(posedge tick);
        link_a2 <= a2;
        link_bc4 <= bc4;
        link_wr_cmd <= 1'b1;
        repeat (8) @(posedge tick);
        // data leads the strobe by one tick and is held three ticks after it
        for (int b = 0; b < n; b++) begin
            link_dq <= {ui[b].hi[7:0], ui[b].lo[7:0]};
            link_dm_n <= {ui[b].hi[8], ui[b].lo[8]};
            @(posedge tick);
            link_strobe <= ~link_strobe;
            repeat (3) @(posedge tick);
        end
        link_wr_cmd <= 1'b0;
        link_dq <= ~link_dq;
        link_dm_n <= ~link_dm_n;
    endtask : send
endmodule : link_host_model
`default_nettype wire

/* File: bench/write_crc_bc4_checker_bench.sv */
// self-checking bench for the write crc checker
`timescale 1ns/10ps
`default_nettype none
module write_crc_bc4_checker_bench;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic link_strobe;
    logic link_wr_cmd;
    logic link_a2;
    logic link_bc4;
    logic [15:0] link_dq;
    logic [1:0] link_dm_n;
    logic arr_wr_valid;
    logic [127:0] arr_data;
    logic [15:0] arr_keep;
    logic pda_sel;
    logic irq;
    int error_cnt;
    int check_count;
    int n_commit;
    logic [7:0][15:0] dq_v;
    logic [7:0][1:0] dm_v;

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    write_crc_bc4_checker write_crc_bc4_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_strobe(link_strobe), .link_wr_cmd(link_wr_cmd),
        .link_a2(link_a2), .link_bc4(link_bc4), .link_dq(link_dq), .link_dm_n(link_dm_n),
        .arr_wr_valid(arr_wr_valid), .arr_data(arr_data), .arr_keep(arr_keep), .pda_sel(pda_sel), .irq(irq));

    link_host_model link_host_model_inst (.link_strobe(link_strobe), .link_wr_cmd(link_wr_cmd),
        .link_a2(link_a2), .link_bc4(link_bc4), .link_dq(link_dq), .link_dm_n(link_dm_n));

    always @(posedge pclk) begin
        if (arr_wr_valid === 1'b1) n_commit <= n_commit + 1;
    end

    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // no cycle count assumed for the answer: only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
            output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        check(what, {96'h0, exp & m}, {96'h0, q & m});
    endtask : rd_chk

    // ctl bits: crc, mask lanes, half masking, x8, per-device
    task automatic frame(input logic [4:0] ctl, input logic a2, input logic bc4, input logic [1:0] bad);
        logic [1:0] fail;
        logic ok;
        logic [15:0] win;
        logic [15:0] kexp;
        logic [127:0] dmask;
        logic [127:0] ed;
        logic [7:0] cl;
        logic [7:0] ch;
        int c0;
        int s;
        {win, kexp, dmask, ed} = '0;
        wr(crc_chk_pkg::ADDR_CTRL, {27'h0, ctl});
        wr(crc_chk_pkg::ADDR_STAT, 32'h1f);
        c0 = n_commit;
        link_host_model_inst.send(a2, bc4, ctl[0], ctl[1], dq_v, dm_v, bad);
        repeat (24) @(posedge pclk);
        fail = ctl[0] ? (bad & {~ctl[3], 1'b1}) : 2'b00;
        ok = !ctl[4] && (fail == 2'b00 || (ctl[2] && fail != 2'b11));
        check("commit count", {127'h0, ok}, 128'(n_commit - c0));
        for (int b = 0; b < 8; b++) begin
            s = (a2 && bc4) ? b - 4 : b;
            if (!bc4 || (s >= 0 && s < 4)) begin
                win[2*b +: 2] = 2'b11;
                dmask[16*b +: 16] = 16'hffff;
                ed[16*b +: 16] = dq_v[s];
                kexp[2*b] = !(ctl[2] && fail[0]) && (!ctl[1] || dm_v[s][0]);
                kexp[2*b+1] = !ctl[3] && !(ctl[2] && fail[1]) && (!ctl[1] || dm_v[s][1]);
            end
        end
        if (ok) check("array data", ed, arr_data & dmask);
        if (ok) check("array keep", {112'h0, kexp}, {112'h0, arr_keep & win});
        rd_chk(crc_chk_pkg::ADDR_STAT, 32'h1f, {27'h0, ctl[4] && !dq_v[0][0], ctl[4] && ctl[0], 1'b1, fail},
            "status");
        cl = link_host_model_inst.calc_lo;
        ch = link_host_model_inst.calc_hi;
        if (ctl[0]) rd_chk(crc_chk_pkg::ADDR_CRC, ctl[3] ? 32'h00ff00ff : 32'hffffffff,
            {ch ^ {7'h0, bad[1]}, cl ^ {7'h0, bad[0]}, ch, cl}, "crc register");
        if (ctl[4]) check("pda select", {127'h0, !dq_v[0][0]}, {127'h0, pda_sel});
        $display("test frame ctl %h a2 %b bc4 %b bad %b finished", ctl, a2, bc4, bad);
    endtask : frame

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    initial begin
        #400000;
        error_cnt++;
        stop_test();
    end

    initial begin
        logic [31:0] q;
        logic e;
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {error_cnt, check_count, n_commit} = {32'd0, 32'd0, 32'd0};
        dq_v = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
        dm_v = 16'hffff;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(crc_chk_pkg::ADDR_CTRL, 32'hffffffff, {27'h0, crc_chk_pkg::CTRL_RST}, "ctrl reset");
        rd_chk(crc_chk_pkg::ADDR_STAT, 32'hffffffff, {27'h0, crc_chk_pkg::STAT_RST}, "stat reset");
        rd_chk(crc_chk_pkg::ADDR_MASK, 32'hffffffff, {27'h0, crc_chk_pkg::MASK_RST}, "mask reset");
        apb(1'b1, 8'h10, 32'h1, q, e);
        check("unmapped write error", 128'h1, {127'h0, e});
        apb(1'b0, 8'h10, 32'h0, q, e);
        check("unmapped read", 128'h1_0000_0000, {95'h0, e, q});
        wr(crc_chk_pkg::ADDR_CTRL, 32'hffffffff);
        rd_chk(crc_chk_pkg::ADDR_CTRL, 32'hffffffff, 32'h1f, "ctrl reserved bits");
        $display("test registers finished");
        frame(5'h01, 1'b1, 1'b1, 2'b00);
        frame(5'h01, 1'b0, 1'b1, 2'b00);
        dm_v = 16'hffd7;
        frame(5'h03, 1'b1, 1'b1, 2'b00);
        frame(5'h03, 1'b0, 1'b1, 2'b00);
        frame(5'h09, 1'b0, 1'b1, 2'b00);
        frame(5'h0b, 1'b1, 1'b1, 2'b00);
        dm_v = 16'hffff;
        frame(5'h09, 1'b1, 1'b1, 2'b01);
        frame(5'h01, 1'b0, 1'b0, 2'b00);
        frame(5'h00, 1'b0, 1'b0, 2'b00);
        frame(5'h00, 1'b1, 1'b1, 2'b00);
        for (int h = 0; h < 2; h++) begin
            for (int k = 1; k < 4; k++) frame({2'b00, h[0], 2'b01}, 1'b1, 1'b1, k[1:0]);
        end
        frame(5'h01, 1'b1, 1'b1, 2'b00);
        dq_v[0][0] = 1'b0;
        frame(5'h10, 1'b0, 1'b1, 2'b00);
        dq_v[0][0] = 1'b1;
        frame(5'h10, 1'b0, 1'b1, 2'b00);
        frame(5'h11, 1'b0, 1'b1, 2'b00);
        wr(crc_chk_pkg::ADDR_MASK, 32'h4);
        frame(5'h01, 1'b1, 1'b1, 2'b00);
        check("irq raised", 128'h1, {127'h0, irq});
        wr(crc_chk_pkg::ADDR_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq masked", 128'h0, {127'h0, irq});
        wr(crc_chk_pkg::ADDR_MASK, 32'h4);
        repeat (2) @(posedge pclk);
        check("irq unmasked", 128'h1, {127'h0, irq});
        wr(crc_chk_pkg::ADDR_STAT, 32'h4);
        repeat (2) @(posedge pclk);
        check("irq cleared", 128'h0, {127'h0, irq});
        rd_chk(crc_chk_pkg::ADDR_STAT, 32'h04, 32'h0, "done cleared");
        $display("test interrupt finished");
        stop_test();
    end
endmodule : write_crc_bc4_checker_bench
`default_nettype wire

/* File: logic/crc_chk_pkg.sv */
// constants, field layout and carrier types for the write crc checker
`default_nettype none
package crc_chk_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_CRC = 8'h0c;
    // control field positions
    localparam int CTL_CRC_EN = 0;
    localparam int CTL_DM_EN = 1;
    localparam int CTL_HALF = 2;
    localparam int CTL_X8 = 3;
    localparam int CTL_PDA = 4;
    localparam int CTL_W = 5;
    localparam logic [CTL_W-1:0] CTRL_RST = 5'h00;
    // status / mask field positions
    localparam int ST_ERR_LO = 0;
    localparam int ST_ERR_HI = 1;
    localparam int ST_DONE = 2;
    localparam int ST_ILLEGAL = 3;
    localparam int ST_PDA_SEL = 4;
    localparam int ST_W = 5;
    localparam logic [ST_W-1:0] STAT_RST = 5'h00;
    localparam logic [ST_W-1:0] MASK_RST = 5'h00;
    // frame geometry
    localparam logic [3:0] UI_CRC = 4'ha;
    localparam logic [3:0] UI_PLAIN = 4'h8;
    localparam int BEATS = 10;
    localparam int DATA_BEATS = 8;
    localparam int CHOP_BEATS = 4;
    localparam int CRC_BEAT = 8;
    localparam int TREE_W = 72;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    localparam logic [15:0] KEEP_LO = 16'h5555;
    localparam logic [15:0] KEEP_HI = 16'haaaa;

    // both byte groups on one unit interval: bit 8 of each is the mask/inversion lane
    typedef struct packed {
        logic [8:0] hi;
        logic [8:0] lo;
    } beat_t;

    // link pins as sampled together
    typedef struct packed {
        logic cmd;
        logic a2;
        logic bc4;
        logic strobe;
        logic [1:0] dm_n;
        logic [15:0] dq;
    } pins_t;
endpackage : crc_chk_pkg
`default_nettype wire

/* File: logic/crc_tree_byte.sv */
// crc tree for one byte group: builds the 72 tree inputs and checks them
`timescale 1ns/10ps
`default_nettype none
module crc_tree_byte (
    // captured frame, beat 0 first, bit 8 of each beat is the mask lane
    input wire logic [9:0][8:0] ui,
    // frame options
    input wire logic bc4,
    input wire logic dm_en,
    // result
    output logic [7:0] calc,
    output logic [7:0] rx,
    output logic mismatch
);
    // tree input index is lane*8+beat, lane 8 being the mask lane
    function automatic logic [crc_chk_pkg::TREE_W-1:0] tree_build(input logic [9:0][8:0] u,
            input logic chop, input logic dm);
        logic [crc_chk_pkg::TREE_W-1:0] t;
        t = '1;
        for (int l = 0; l < 9; l++) begin
            for (int b = 0; b < crc_chk_pkg::DATA_BEATS; b++) begin
                // a2 high: upper nibble rides beats 0-3 and takes the lower nibble's places
                if (!chop || b < crc_chk_pkg::CHOP_BEATS) begin
                    t[l*8+b] = u[b][l];
                end
            end
        end
        if (!dm) begin
            t[71:64] = '1;
        end
        return t;
    endfunction : tree_build

    // serial form of x^8+x^2+x+1, highest index first so input i weighs x^(i+8)
    function automatic logic [7:0] crc8(input logic [crc_chk_pkg::TREE_W-1:0] t);
        logic [7:0] c;
        logic fb;
        c = crc_chk_pkg::CRC_INIT;
        for (int i = crc_chk_pkg::TREE_W - 1; i >= 0; i--) begin
            fb = c[7] ^ t[i];
            c = {c[6:0], 1'b0} ^ (fb ? crc_chk_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8

    always_comb begin
        calc = crc8(tree_build(ui, bc4, dm_en));
        for (int j = 0; j < 8; j++) begin
            rx[j] = ui[crc_chk_pkg::CRC_BEAT][j];
        end
        mismatch = (calc != rx);
    end
endmodule : crc_tree_byte
`default_nettype wire

/* File: logic/write_crc_bc4_checker.sv */
// write crc checker for chopped and full write bursts, with apb control
// Function
// - crc frames last ten unit intervals
// - chop lane: data, ones, crc, one
// - a2 high moves upper nibble into tree
// - lower mask lane forced ones unless enabled
// - upper mask lane forced ones unless enabled
// - x8 a2 low: unused beats are ones
// - x8 a2 high: upper nibble, rest ones
// - crc checked before array commit
// - mismatch drops the whole write under full masking
// - x16 masks all or half lanes
// - half mask: lower error blocks lanes 0-7
// - half mask: upper error blocks lanes 8-15
// - per-device mode: mode sets, lane 0 selects
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module write_crc_bc4_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // write link pins
    input wire logic link_strobe,
    input wire logic link_wr_cmd,
    input wire logic link_a2,
    input wire logic link_bc4,
    input wire logic [15:0] link_dq,
    input wire logic [1:0] link_dm_n,
    // array write path
    output logic arr_wr_valid,
    output logic [127:0] arr_data,
    output logic [15:0] arr_keep,
    // status
    output logic pda_sel,
    output logic irq
);
    typedef enum logic [1:0] {S_IDLE, S_CAPT, S_CHECK} state_t;

    crc_chk_pkg::pins_t s1_r, s2_r, s3_r;
    crc_chk_pkg::beat_t beats_r [0:crc_chk_pkg::BEATS-1];
    state_t state_r;
    logic [3:0] ui_cnt_r, frm_len_r;
    logic frm_a2_r, frm_bc4_r;
    logic [crc_chk_pkg::CTL_W-1:0] ctrl_r;
    logic [crc_chk_pkg::ST_W-1:0] sts_r, msk_r;
    logic [31:0] crc_seen_r, prdata_r;
    logic pready_r, pslverr_r, irq_r, pda_sel_r;
    logic arr_wr_valid_r;
    logic [127:0] arr_data_r;
    logic [15:0] arr_keep_r;

    logic strb_edge, cmd_rise, wr_acc, rd_setup;
    logic [9:0][8:0] lo_ui, hi_ui;
    logic [7:0] calc_lo, calc_hi, rx_lo, rx_hi;
    logic mis_lo, mis_hi;
    logic crc_on, err_lo, err_hi, any_err, commit;
    logic [127:0] data_nxt;
    logic [15:0] keep_nxt;
    logic [crc_chk_pkg::ST_W-1:0] ev_set;

    // pins come from the strobe domain: two stages before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= {link_wr_cmd, link_a2, link_bc4, link_strobe, link_dm_n, link_dq};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // each strobe transition, either way, marks one unit interval
    assign strb_edge = s2_r.strobe ^ s3_r.strobe;
    assign cmd_rise = s2_r.cmd & ~s3_r.cmd;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_IDLE;
            ui_cnt_r <= 4'h0;
            frm_len_r <= crc_chk_pkg::UI_PLAIN;
            frm_a2_r <= 1'b0;
            frm_bc4_r <= 1'b0;
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (cmd_rise) begin
                        state_r <= S_CAPT;
                        ui_cnt_r <= 4'h0;
                        frm_a2_r <= s2_r.a2;
                        frm_bc4_r <= s2_r.bc4;
                        // chop or not, a crc frame is always ten intervals long
                        frm_len_r <= ctrl_r[crc_chk_pkg::CTL_CRC_EN] ? crc_chk_pkg::UI_CRC
                                                                     : crc_chk_pkg::UI_PLAIN;
                    end
                end
                S_CAPT: begin
                    if (strb_edge) begin
                        ui_cnt_r <= ui_cnt_r + 4'h1;
                        if (ui_cnt_r == frm_len_r - 4'h1) begin
                            state_r <= S_CHECK;
                        end
                    end
                end
                S_CHECK: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // frame storage; beats beyond the frame length keep ones so no stale crc is seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < crc_chk_pkg::BEATS; i++) begin
                beats_r[i] <= '1;
            end
        end else if (state_r == S_IDLE && cmd_rise) begin
            for (int i = 0; i < crc_chk_pkg::BEATS; i++) begin
                beats_r[i] <= '1;
            end
        end else if (state_r == S_CAPT && strb_edge) begin
            beats_r[ui_cnt_r] <= '{hi: {s2_r.dm_n[1], s2_r.dq[15:8]}, lo: {s2_r.dm_n[0], s2_r.dq[7:0]}};
        end
    end

    always_comb begin
        for (int i = 0; i < crc_chk_pkg::BEATS; i++) begin
            lo_ui[i] = beats_r[i].lo;
            hi_ui[i] = beats_r[i].hi;
        end
    end

    // two identical trees, one per byte group; x8 uses only the lower one
    crc_tree_byte u_tree_lo (
        .ui(lo_ui),
        .bc4(frm_bc4_r),
        .dm_en(ctrl_r[crc_chk_pkg::CTL_DM_EN]),
        .calc(calc_lo),
        .rx(rx_lo),
        .mismatch(mis_lo)
    );

    crc_tree_byte u_tree_hi (
        .ui(hi_ui),
        .bc4(frm_bc4_r),
        .dm_en(ctrl_r[crc_chk_pkg::CTL_DM_EN]),
        .calc(calc_hi),
        .rx(rx_hi),
        .mismatch(mis_hi)
    );

    // commit decision, taken only once the whole frame and its crc are in
    always_comb begin
        crc_on = ctrl_r[crc_chk_pkg::CTL_CRC_EN] && (frm_len_r == crc_chk_pkg::UI_CRC);
        err_lo = crc_on & mis_lo;
        err_hi = crc_on & mis_hi & ~ctrl_r[crc_chk_pkg::CTL_X8];
        any_err = err_lo | err_hi;
        data_nxt = '0;
        keep_nxt = '0;
        for (int b = 0; b < crc_chk_pkg::DATA_BEATS; b++) begin
            // a chop with a2 high lands in the upper half of the burst
            if (frm_bc4_r && frm_a2_r && b >= crc_chk_pkg::CHOP_BEATS) begin
                data_nxt[b*16 +: 16] = {beats_r[b-4].hi[7:0], beats_r[b-4].lo[7:0]};
                keep_nxt[2*b] = ~ctrl_r[crc_chk_pkg::CTL_DM_EN] | beats_r[b-4].lo[8];
                keep_nxt[2*b+1] = ~ctrl_r[crc_chk_pkg::CTL_DM_EN] | beats_r[b-4].hi[8];
            end else if (!frm_bc4_r || (!frm_a2_r && b < crc_chk_pkg::CHOP_BEATS)) begin
                data_nxt[b*16 +: 16] = {beats_r[b].hi[7:0], beats_r[b].lo[7:0]};
                keep_nxt[2*b] = ~ctrl_r[crc_chk_pkg::CTL_DM_EN] | beats_r[b].lo[8];
                keep_nxt[2*b+1] = ~ctrl_r[crc_chk_pkg::CTL_DM_EN] | beats_r[b].hi[8];
            end
        end
        if (err_lo) begin
            keep_nxt = keep_nxt & ~crc_chk_pkg::KEEP_LO;
        end
        if (err_hi || ctrl_r[crc_chk_pkg::CTL_X8]) begin
            keep_nxt = keep_nxt & ~crc_chk_pkg::KEEP_HI;
        end
        // full masking drops everything on any error; half masking keeps the clean byte
        commit = !ctrl_r[crc_chk_pkg::CTL_PDA] && (ctrl_r[crc_chk_pkg::CTL_HALF] ? !(err_lo && (err_hi
                 || ctrl_r[crc_chk_pkg::CTL_X8])) : !any_err);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arr_wr_valid_r <= 1'b0;
            arr_data_r <= '0;
            arr_keep_r <= '0;
            crc_seen_r <= '0;
            pda_sel_r <= 1'b0;
        end else begin
            arr_wr_valid_r <= (state_r == S_CHECK) && commit;
            if (state_r == S_CHECK) begin
                crc_seen_r <= {rx_hi, rx_lo, calc_hi, calc_lo};
                if (commit) begin
                    arr_data_r <= data_nxt;
                    arr_keep_r <= keep_nxt;
                end
                // per-device frames carry a mode set; lane 0 low on the first beat selects us
                if (ctrl_r[crc_chk_pkg::CTL_PDA]) begin
                    pda_sel_r <= ~beats_r[0].lo[0];
                end
            end
        end
    end

    // events for the sticky status bits
    always_comb begin
        ev_set = '0;
        ev_set[crc_chk_pkg::ST_ERR_LO] = (state_r == S_CHECK) && err_lo;
        ev_set[crc_chk_pkg::ST_ERR_HI] = (state_r == S_CHECK) && err_hi;
        ev_set[crc_chk_pkg::ST_DONE] = (state_r == S_CHECK);
        // crc with per-device addressing is a forbidden setup; flag it while it stands
        ev_set[crc_chk_pkg::ST_ILLEGAL] = ctrl_r[crc_chk_pkg::CTL_PDA]
                                        & ctrl_r[crc_chk_pkg::CTL_CRC_EN];
        ev_set[crc_chk_pkg::ST_PDA_SEL] = (state_r == S_CHECK) && ctrl_r[crc_chk_pkg::CTL_PDA]
                                        && !beats_r[0].lo[0];
    end

    // apb: answer in the first access cycle, registered from the setup cycle
    assign rd_setup = psel && !penable;
    assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end else begin
            pready_r <= rd_setup;
            if (rd_setup) begin
                pslverr_r <= 1'b0;
                prdata_r <= '0;
                unique case (paddr)
                    crc_chk_pkg::ADDR_CTRL: prdata_r[crc_chk_pkg::CTL_W-1:0] <= ctrl_r;
                    crc_chk_pkg::ADDR_STAT: prdata_r[crc_chk_pkg::ST_W-1:0] <= sts_r;
                    crc_chk_pkg::ADDR_MASK: prdata_r[crc_chk_pkg::ST_W-1:0] <= msk_r;
                    crc_chk_pkg::ADDR_CRC: prdata_r <= crc_seen_r;
                    default: pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= crc_chk_pkg::CTRL_RST;
            msk_r <= crc_chk_pkg::MASK_RST;
        end else if (wr_acc) begin
            if (paddr == crc_chk_pkg::ADDR_CTRL) begin
                ctrl_r <= pwdata[crc_chk_pkg::CTL_W-1:0];
            end
            if (paddr == crc_chk_pkg::ADDR_MASK) begin
                msk_r <= pwdata[crc_chk_pkg::ST_W-1:0];
            end
        end
    end

    // write-one-to-clear; a new event in the same cycle wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_r <= crc_chk_pkg::STAT_RST;
        end else if (wr_acc && paddr == crc_chk_pkg::ADDR_STAT) begin
            sts_r <= (sts_r & ~pwdata[crc_chk_pkg::ST_W-1:0]) | ev_set;
        end else begin
            sts_r <= sts_r | ev_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(sts_r & msk_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign arr_wr_valid = arr_wr_valid_r;
    assign arr_data = arr_data_r;
    assign arr_keep = arr_keep_r;
    assign pda_sel = pda_sel_r;
    assign irq = irq_r;

    a_frame_len:
    assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_CAPT |-> ui_cnt_r < frm_len_r)
        else $error("unit interval count ran past the frame length");

    a_commit_order:
    assert property (@(posedge pclk) disable iff (!presetn)
        arr_wr_valid_r |-> $past(state_r) == S_CHECK && $past(state_r, 2) == S_CAPT)
        else $error("array write without a completed and checked frame");

    a_drop_full:
    assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_CHECK && any_err && !ctrl_r[crc_chk_pkg::CTL_HALF] |=> !arr_wr_valid_r)
        else $error("failing frame reached the array under full masking");

    a_half_lo:
    assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_CHECK && err_lo && !err_hi && ctrl_r[crc_chk_pkg::CTL_HALF]
        && !ctrl_r[crc_chk_pkg::CTL_X8] && !ctrl_r[crc_chk_pkg::CTL_PDA]
        |=> arr_wr_valid_r && (arr_keep_r & crc_chk_pkg::KEEP_LO) == 16'h0000)
        else $error("lower byte not blocked after lower tree error");

    a_half_hi:
    assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_CHECK && err_hi && !err_lo && ctrl_r[crc_chk_pkg::CTL_HALF]
        && !ctrl_r[crc_chk_pkg::CTL_PDA]
        |=> arr_wr_valid_r && (arr_keep_r & crc_chk_pkg::KEEP_HI) == 16'h0000)
        else $error("upper byte not blocked after upper tree error");

    a_illegal_flag:
    assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[crc_chk_pkg::CTL_PDA] && ctrl_r[crc_chk_pkg::CTL_CRC_EN]
        |=> sts_r[crc_chk_pkg::ST_ILLEGAL])
        else $error("forbidden crc and per-device setup not flagged");

    a_pda_no_write:
    assert property (@(posedge pclk) disable iff (!presetn)
        state_r == S_CHECK && ctrl_r[crc_chk_pkg::CTL_PDA] |=> !arr_wr_valid_r ##1 !arr_wr_valid_r)
        else $error("array written during per-device addressing");

    a_irq_level:
    assert property (@(posedge pclk) disable iff (!presetn)
        ##1 irq_r == |($past(sts_r) & $past(msk_r)))
        else $error("interrupt does not follow masked status");

    a_apb_ready:
    assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready_r ##1 !pready_r || (psel && !penable))
        else $error("apb answer not one access cycle");
endmodule : write_crc_bc4_checker
`default_nettype wire
